// >>> mad_pkg.sv
// Constants, types and carriers for the memory address map decoder
// Overview of operation
// - Program word 24 bits, phantom top byte zero
// - Lower half even address, upper half odd
// - Program counter even, steps by two
// - Region below 000200h reserved for vectors
// - Fetch starts at zero; jump placed there
// - Primary and alternate vector tables decoded
// - Top two words copied to configuration at reset
// - Configuration pair placed by memory size
// - Separate read and write address units
// - Effective address 16 bits, byte granular
// - Top address bit selects program window
// - 8 Kbytes implemented; outside reads zero
// - Even byte least significant, odd most
package mad_pkg;
    // Widths of the two spaces
    localparam int PA_W  = 24;                  // Program byte-style address width
    localparam int PW_W  = 24;                  // Program word width
    localparam int EA_W  = 16;                  // Data effective address width
    localparam int DW_W  = 16;                  // Data word width
    localparam int RAM_BYTES = 8192;            // Implemented data memory bytes
    localparam int RAM_AW    = 12;              // Word index width of data memory

    // Program space landmarks
    localparam logic [PA_W-1:0] PC_RESET     = 24'h000000; // Fetch start after reset
    localparam logic [PA_W-1:0] IVT_PRI_LO   = 24'h000004; // Primary table start
    localparam logic [PA_W-1:0] IVT_PRI_HI   = 24'h0000ff; // Primary table end
    localparam logic [PA_W-1:0] IVT_ALT_LO   = 24'h000100; // Alternate table start
    localparam logic [PA_W-1:0] VEC_END      = 24'h000200; // First address for code
    localparam logic [PA_W-1:0] PC_STEP      = 24'h000002; // One instruction word

    // Program memory sizes in words, and their configuration pair locations
    localparam int PM_WORDS_5K5 = 5632;         // 5.5K words
    localparam int PM_WORDS_11K = 11264;        // 11K words
    localparam int PM_WORDS_16K = 16896;        // 16K class, pair at 0083fc
    localparam int PM_WORDS_22K = 22016;        // 22K class, pair at 00abfc
    localparam logic [PA_W-1:0] CFG_OFFSET = 24'h000004; // Pair sits this far below top

    // Fetch region seen at the program counter
    typedef enum logic [2:0] {
        MAD_REG_RESET_VEC,                      // Reset vector words
        MAD_REG_IVT_PRI,                        // Primary interrupt vector table
        MAD_REG_IVT_ALT,                        // Alternate interrupt vector table
        MAD_REG_CODE,                           // Ordinary code
        MAD_REG_CONFIG                          // Configuration pair
    } mad_region_t;

    // Data target chosen by the decoder
    typedef enum logic [1:0] {
        MAD_TGT_RAM,                            // Implemented data memory
        MAD_TGT_WIN,                            // Program space window
        MAD_TGT_ZERO                            // Unimplemented, reads zero
    } mad_target_t;

    // Request from one address generation unit
    typedef struct packed {
        logic            en;                    // Request valid
        logic            byte_mode;             // Byte access, else word
        logic [EA_W-1:0] ea;                    // Effective address
        logic [DW_W-1:0] wdata;                 // Write data, byte in low bits
    } mad_agu_req_t;

    // Request toward one port of data memory
    typedef struct packed {
        logic              en;                  // Access strobe
        logic [RAM_AW-1:0] widx;                // Word index in data memory
        logic [1:0]        be;                  // Byte lanes: bit0 even, bit1 odd
        logic [DW_W-1:0]   wdata;               // Lane-placed write data
    } mad_ram_req_t;
endpackage : mad_pkg

// >>> mad_ea_decode.sv
// Combinational decode of one data effective address
`timescale 1ns/100ps
module mad_ea_decode
    import mad_pkg::*;
(
    input  wire logic [mad_pkg::EA_W-1:0]   ea,        // Effective address
    input  wire logic                       byte_mode, // Byte access
    output      mad_pkg::mad_target_t       target,    // Selected target
    output      logic [mad_pkg::RAM_AW-1:0] widx,      // Data memory word index
    output      logic [1:0]                 be         // Byte lanes touched
);
    // Implemented area limit as a byte address
    localparam logic [EA_W-1:0] RAM_LIMIT = EA_W'(RAM_BYTES);

    wire is_win = ea[EA_W-1];
    wire in_ram = (ea < RAM_LIMIT);

    assign target = is_win ? MAD_TGT_WIN : (in_ram ? MAD_TGT_RAM : MAD_TGT_ZERO);

    assign widx = ea[RAM_AW:1];

    assign be = byte_mode ? (ea[0] ? 2'b10 : 2'b01) : 2'b11;
endmodule : mad_ea_decode

// >>> mad_decoder.sv
// Program and data address map decoder with reset configuration copy
`timescale 1ns/100ps
module mad_decoder
    import mad_pkg::*;
#(
    parameter int PM_WORDS = 22016              // Program memory size in words
) (
    input  wire logic                        clk,         // Core clock
    input  wire logic                        reset,       // Async reset, active high
    // Program memory port, data one cycle after the strobe
    output      logic                        pm_rd,       // Read strobe
    output      logic [mad_pkg::PA_W-1:0]    pm_addr,     // Even word address
    input  wire logic [mad_pkg::PW_W-1:0]    pm_rdata,    // 24-bit word
    // Instruction fetch
    input  wire logic                        fetch_req,   // Fetch at counter and step
    input  wire logic                        fetch_back,  // Step backward
    output      logic                        fetch_ready, // Fetch accepted this cycle
    input  wire logic                        pc_load,     // Load jump target
    input  wire logic [mad_pkg::PA_W-1:0]    pc_target,   // Jump target
    output      logic [mad_pkg::PA_W-1:0]    pc,          // Program counter
    output      mad_pkg::mad_region_t        pc_region,   // Region of counter
    output      logic                        fetch_valid, // Instruction valid
    output      logic [mad_pkg::PW_W-1:0]    fetch_word,  // Instruction word
    // Half-word program reads
    input  wire logic                        hw_req,      // Half-word read request
    input  wire logic [mad_pkg::PA_W-1:0]    hw_addr,     // Half-word address
    output      logic                        hw_ready,    // Request accepted
    output      logic                        hw_valid,    // Result valid
    output      logic [mad_pkg::DW_W-1:0]    hw_data,     // Half-word result
    // Configuration copy
    output      logic                        cfg_valid,   // Copy complete
    output      logic [mad_pkg::PW_W-1:0]    cfg_word1,   // First configuration word
    output      logic [mad_pkg::PW_W-1:0]    cfg_word2,   // Second configuration word
    // Data read and write address units
    input  wire mad_pkg::mad_agu_req_t       rd_agu,      // Read unit request
    input  wire mad_pkg::mad_agu_req_t       wr_agu,      // Write unit request
    output      logic                        rd_valid,    // Read result valid
    output      logic [mad_pkg::DW_W-1:0]    rd_data,     // Read result
    // Data memory, dual port, read data in the strobe cycle
    output      mad_pkg::mad_ram_req_t       ram_rd,      // Read request
    input  wire logic [mad_pkg::DW_W-1:0]    ram_rdata,   // Read data
    output      mad_pkg::mad_ram_req_t       ram_wr,      // Write request
    // Program space window, data in the strobe cycle
    output      logic                        win_rd,      // Window read strobe
    output      logic [mad_pkg::EA_W-1:0]    win_ea,      // Untranslated address
    input  wire logic [mad_pkg::DW_W-1:0]    win_rdata    // Window read data
);
    // Configuration pair location follows the array size
    // pair placed by array size
    localparam logic [PA_W-1:0] CFG_ADDR1 = PA_W'(PM_WORDS * 2) - CFG_OFFSET;
    localparam logic [PA_W-1:0] CFG_ADDR2 = CFG_ADDR1 + PC_STEP;

    // Sequencer: configuration copy precedes any fetch
    typedef enum logic [1:0] {ST_CFG1, ST_CFG2, ST_CFG_LAST, ST_RUN} mad_state_t;

    mad_state_t              state_q;         // Current state
    mad_state_t              state_d;         // Next state
    logic [PA_W-1:0]         pc_q;            // Program counter
    logic [PA_W-1:0]         pc_d;            // Next counter
    logic                    fetch_pend_q;    // Fetch data arrives now
    logic                    hw_pend_q;       // Half-word data arrives now
    logic                    hw_odd_q;        // Half-word was the upper half
    logic                    fetch_valid_q;   // Registered fetch valid
    logic [PW_W-1:0]         fetch_word_q;    // Registered instruction
    logic                    hw_valid_q;      // Registered half-word valid
    logic [DW_W-1:0]         hw_data_q;       // Registered half-word
    logic                    cfg_valid_q;     // Copy complete
    logic [PW_W-1:0]         cfg_word1_q;     // First configuration word
    logic [PW_W-1:0]         cfg_word2_q;     // Second configuration word
    mad_ram_req_t            ram_rd_q;        // Registered read request
    mad_ram_req_t            ram_wr_q;        // Registered write request
    logic                    win_rd_q;        // Registered window strobe
    logic [EA_W-1:0]         win_ea_q;        // Registered window address
    logic                    rd_pend_q;       // Read data due from a target
    mad_target_t             rd_tgt_q;        // Target of pending read
    logic                    rd_byte_q;       // Pending read is a byte
    logic                    rd_odd_q;        // Pending read is the odd byte
    logic                    rd_valid_q;      // Registered read valid
    logic [DW_W-1:0]         rd_data_q;       // Registered read data

    // Decoder outputs for the two address units
    mad_target_t             rd_tgt;          // Read unit target
    mad_target_t             wr_tgt;          // Write unit target
    logic [RAM_AW-1:0]       rd_widx;         // Read word index
    logic [RAM_AW-1:0]       wr_widx;         // Write word index
    logic [1:0]              rd_be;           // Read lanes
    logic [1:0]              wr_be;           // Write lanes

    mad_ea_decode u_rd_dec (
        .ea        (rd_agu.ea),
        .byte_mode (rd_agu.byte_mode),
        .target    (rd_tgt),
        .widx      (rd_widx),
        .be        (rd_be)
    );

    mad_ea_decode u_wr_dec (
        .ea        (wr_agu.ea),
        .byte_mode (wr_agu.byte_mode),
        .target    (wr_tgt),
        .widx      (wr_widx),
        .be        (wr_be)
    );

    // Program port arbitration: copy, then half-word reads, then fetch
    wire running  = (state_q == ST_RUN);
    wire hw_take  = running & hw_req;
    wire fetch_take = running & fetch_req & ~hw_req;
    wire pc_bump  = fetch_take;

    // half-word address pairs onto its even word
    wire [PA_W-1:0] hw_word_addr = {hw_addr[PA_W-1:1], 1'b0};

    assign hw_ready    = running;
    assign fetch_ready = fetch_take;

    assign pm_rd   = (state_q == ST_CFG1) | (state_q == ST_CFG2) | hw_take | fetch_take;
    assign pm_addr = (state_q == ST_CFG1) ? CFG_ADDR1 :
                     (state_q == ST_CFG2) ? CFG_ADDR2 :
                     hw_take ? hw_word_addr : pc_q;

    wire [PA_W-1:0] pc_stepped = fetch_back ? (pc_q - PC_STEP) : (pc_q + PC_STEP);
    wire [PA_W-1:0] pc_jump    = {pc_target[PA_W-1:1], 1'b0};

    // Jump beats a step issued in the same cycle
    always_comb begin
        pc_d = pc_q;
        if (running && pc_load) begin
            pc_d = pc_jump;
        end else if (pc_bump) begin
            pc_d = pc_stepped;
        end
    end

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_CFG1:     state_d = ST_CFG2;
            ST_CFG2:     state_d = ST_CFG_LAST;
            ST_CFG_LAST: state_d = ST_RUN;
            ST_RUN:      state_d = ST_RUN;
        endcase
    end

    assign pc_region = (pc_q <  IVT_PRI_LO)                     ? MAD_REG_RESET_VEC :
                       (pc_q <= IVT_PRI_HI)                     ? MAD_REG_IVT_PRI   :
                       (pc_q <  VEC_END)                        ? MAD_REG_IVT_ALT   :
                       (pc_q == CFG_ADDR1 || pc_q == CFG_ADDR2) ? MAD_REG_CONFIG    :
                                                                  MAD_REG_CODE;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_CFG1;
            pc_q    <= PC_RESET;
        end else begin
            state_q <= state_d;
            pc_q    <= pc_d;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_valid_q <= 1'b0;
            cfg_word1_q <= '0;
            cfg_word2_q <= '0;
        end else begin
            if (state_q == ST_CFG2) cfg_word1_q <= pm_rdata;
            if (state_q == ST_CFG_LAST) begin
                cfg_word2_q <= pm_rdata;
                cfg_valid_q <= 1'b1;
            end
        end
    end

    // Program read results, valid two cycles after the strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fetch_pend_q  <= 1'b0;
            hw_pend_q     <= 1'b0;
            hw_odd_q      <= 1'b0;
            fetch_valid_q <= 1'b0;
            fetch_word_q  <= '0;
            hw_valid_q    <= 1'b0;
            hw_data_q     <= '0;
        end else begin
            fetch_pend_q  <= fetch_take;
            hw_pend_q     <= hw_take;
            hw_odd_q      <= hw_addr[0];
            fetch_valid_q <= fetch_pend_q;
            hw_valid_q    <= hw_pend_q;
            if (fetch_pend_q) fetch_word_q <= pm_rdata;
            if (hw_pend_q) begin
                hw_data_q <= hw_odd_q ? {8'h00, pm_rdata[PW_W-1:DW_W]} : pm_rdata[DW_W-1:0];
            end
        end
    end

    // Lane placement of write data: a byte is copied to both lanes
    wire [DW_W-1:0] wr_lane = wr_agu.byte_mode ? {wr_agu.wdata[7:0], wr_agu.wdata[7:0]}
                                               : wr_agu.wdata;
    wire rd_to_ram = rd_agu.en & (rd_tgt == MAD_TGT_RAM);
    wire rd_to_win = rd_agu.en & (rd_tgt == MAD_TGT_WIN);
    // Window is read only and unimplemented space drops writes
    wire wr_to_ram = wr_agu.en & (wr_tgt == MAD_TGT_RAM);

    // Data request stage
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ram_rd_q  <= '0;
            ram_wr_q  <= '0;
            win_rd_q  <= 1'b0;
            win_ea_q  <= '0;
            rd_pend_q <= 1'b0;
            rd_tgt_q  <= MAD_TGT_ZERO;
            rd_byte_q <= 1'b0;
            rd_odd_q  <= 1'b0;
        end else begin
            ram_rd_q  <= '{en: rd_to_ram, widx: rd_widx, be: rd_be, wdata: '0};
            ram_wr_q  <= '{en: wr_to_ram, widx: wr_widx, be: wr_be, wdata: wr_lane};
            win_rd_q  <= rd_to_win;
            win_ea_q  <= rd_agu.ea;
            rd_pend_q <= rd_agu.en;
            rd_tgt_q  <= rd_tgt;
            rd_byte_q <= rd_agu.byte_mode;
            rd_odd_q  <= rd_agu.ea[0];
        end
    end

    // Source and lane selection of returning read data
    wire [DW_W-1:0] rd_src  = (rd_tgt_q == MAD_TGT_RAM) ? ram_rdata :
                              (rd_tgt_q == MAD_TGT_WIN) ? win_rdata : '0;
    wire [DW_W-1:0] rd_sel  = !rd_byte_q ? rd_src :
                              rd_odd_q ? {8'h00, rd_src[15:8]} : {8'h00, rd_src[7:0]};

    // Data result stage
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_valid_q <= 1'b0;
            rd_data_q  <= '0;
        end else begin
            rd_valid_q <= rd_pend_q;
            if (rd_pend_q) rd_data_q <= rd_sel;
        end
    end

    // Output wiring
    assign pc          = pc_q;
    assign fetch_valid = fetch_valid_q;
    assign fetch_word  = fetch_word_q;
    assign hw_valid    = hw_valid_q;
    assign hw_data     = hw_data_q;
    assign cfg_valid   = cfg_valid_q;
    assign cfg_word1   = cfg_word1_q;
    assign cfg_word2   = cfg_word2_q;
    assign ram_rd      = ram_rd_q;
    assign ram_wr      = ram_wr_q;
    assign win_rd      = win_rd_q;
    assign win_ea      = win_ea_q;
    assign rd_valid    = rd_valid_q;
    assign rd_data     = rd_data_q;
endmodule : mad_decoder

// >>> mad_mem_model.sv
// Behavioural program memory, data memory and window source for the decoder
`timescale 1ns/100ps
module mad_mem_model
    import mad_pkg::*;
(
    input  wire logic                  clk,       // Core clock
    input  wire logic                  pm_rd,     // Program read strobe
    input  wire logic [mad_pkg::PA_W-1:0] pm_addr, // Even word address
    output      logic [mad_pkg::PW_W-1:0] pm_rdata, // Word, one cycle later
    input  wire mad_pkg::mad_ram_req_t ram_rd,    // Data read request
    output      logic [mad_pkg::DW_W-1:0] ram_rdata, // Data in the strobe cycle
    input  wire mad_pkg::mad_ram_req_t ram_wr,    // Data write request
    input  wire logic                  win_rd,    // Window read strobe
    input  wire logic [mad_pkg::EA_W-1:0] win_ea, // Untranslated address
    output      logic [mad_pkg::DW_W-1:0] win_rdata // Window data
);
    logic [DW_W-1:0] mem [0:4095];                // Data words, one per index

    // Known pattern so every read has a predictable answer
    initial begin
        pm_rdata = '0;
        for (int i = 0; i < 4096; i++) mem[i] = 16'(i) ^ 16'h5a3c;
    end

    // full 24-bit word, upper byte nonzero so a lost phantom shows
    // Unstrobed program port toggles, so stale data can never pass for an answer
    always @(posedge clk) begin
        pm_rdata <= pm_rd ? {pm_addr[7:0] ^ 8'hc3, pm_addr[15:0] ^ 16'h3c5a} : ~pm_rdata;
    end

    // Data and window answer while their registered strobe stands; junk otherwise
    assign ram_rdata = ram_rd.en ? mem[ram_rd.widx] : 16'hdead;
    assign win_rdata = win_rd ? {win_ea[7:0], win_ea[15:8]} ^ 16'h0ff0 : 16'hbeef;

    // lane 0 even byte, lane 1 odd byte
    always @(posedge clk) begin
        if (ram_wr.en && ram_wr.be[0]) mem[ram_wr.widx][7:0] <= ram_wr.wdata[7:0];
        if (ram_wr.en && ram_wr.be[1]) mem[ram_wr.widx][15:8] <= ram_wr.wdata[15:8];
    end
endmodule : mad_mem_model

// >>> mad_decoder_checker.sv
// Concurrent checks on the ports of the address map decoder
`timescale 1ns/100ps
module mad_decoder_checker
    import mad_pkg::*;
#(
    parameter int PM_WORDS = 22016                 // Program memory size in words
) (
    input  wire logic                     clk,         // Core clock
    input  wire logic                     reset,       // Async reset
    input  wire logic                     pm_rd,       // Program read strobe
    input  wire logic [mad_pkg::PA_W-1:0] pm_addr,     // Program address
    input  wire logic                     fetch_ready, // Fetch taken
    input  wire logic                     fetch_back,  // Step backward
    input  wire logic                     pc_load,     // Jump load
    input  wire logic [mad_pkg::PA_W-1:0] pc,          // Program counter
    input  wire mad_pkg::mad_region_t     pc_region,   // Counter region
    input  wire logic                     fetch_valid, // Instruction valid
    input  wire logic                     cfg_valid,   // Copy complete
    input  wire mad_pkg::mad_agu_req_t    rd_agu,      // Read unit
    input  wire mad_pkg::mad_agu_req_t    wr_agu,      // Write unit
    input  wire logic                     rd_valid,    // Read result valid
    input  wire logic [mad_pkg::DW_W-1:0] rd_data,     // Read result
    input  wire mad_pkg::mad_ram_req_t    ram_rd,      // Memory read
    input  wire mad_pkg::mad_ram_req_t    ram_wr,      // Memory write
    input  wire logic                     win_rd,      // Window strobe
    input  wire logic [mad_pkg::EA_W-1:0] win_ea       // Window address
);
    // First configuration word sits two words below the top
    localparam logic [PA_W-1:0] CFG1 = PA_W'(PM_WORDS * 2 - 4);

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_pc_even: assert property (pc[0] == 1'b0) else $error("pc odd");
    chk_fetch_fwd: assert property (fetch_ready && !pc_load && !fetch_back |=>
        pc == $past(pc) + PC_STEP) else $error("pc forward step wrong");
    chk_fetch_rev: assert property (fetch_ready && !pc_load && fetch_back |=>
        pc == $past(pc) - PC_STEP) else $error("pc backward step wrong");
    chk_pm_even: assert property (pm_rd |-> !pm_addr[0]) else $error("odd strobe");
    chk_fetch_lat: assert property (fetch_ready |-> ##2 fetch_valid)
        else $error("fetch answer late");
    chk_region_vec: assert property (pc < 24'h000004 |-> pc_region == MAD_REG_RESET_VEC)
        else $error("reset vector region wrong");
    chk_region_pri: assert property (pc >= IVT_PRI_LO && pc <= IVT_PRI_HI |->
        pc_region == MAD_REG_IVT_PRI) else $error("primary table region wrong");
    chk_cfg_copy: assert property ($fell(reset) |-> pm_rd && pm_addr == CFG1
        ##1 pm_addr == CFG1 + 24'h000002 ##2 cfg_valid) else $error("copy order wrong");
    chk_cfg_hold: assert property (cfg_valid |=> cfg_valid) else $error("copy lost");
    chk_ram_route: assert property (rd_agu.en && rd_agu.ea < 16'h2000 |=> ram_rd.en
        && ram_rd.widx == $past(rd_agu.ea[12:1])) else $error("ram route wrong");
    chk_win_route: assert property (rd_agu.en && rd_agu.ea[15] |=> win_rd && !ram_rd.en
        && win_ea == $past(rd_agu.ea)) else $error("window route wrong");
    chk_unimpl_zero: assert property (rd_agu.en && rd_agu.ea[15:13] != 3'h0
        && !rd_agu.ea[15] |-> ##2 rd_valid && rd_data == 16'h0000) else $error("not zero");
    chk_wr_lanes: assert property (wr_agu.en && wr_agu.byte_mode && wr_agu.ea < 16'h2000
        |=> ram_wr.en && ram_wr.be == {$past(wr_agu.ea[0]), !$past(wr_agu.ea[0])})
        else $error("byte lanes wrong");
    chk_wr_drop: assert property (wr_agu.en && wr_agu.ea >= 16'h2000 |=> !ram_wr.en)
        else $error("write outside memory");
endmodule : mad_decoder_checker

bind mad_decoder mad_decoder_checker #(.PM_WORDS(PM_WORDS)) i_mad_decoder_checker (
    .clk, .reset, .pm_rd, .pm_addr, .fetch_ready, .fetch_back, .pc_load, .pc, .pc_region,
    .fetch_valid, .cfg_valid, .rd_agu, .wr_agu, .rd_valid, .rd_data, .ram_rd, .ram_wr,
    .win_rd, .win_ea);

// >>> mad_decoder_tb.sv
// Self-checking testbench for the address map decoder
`timescale 1ns/100ps
module mad_decoder_tb;
    import mad_pkg::*;
    localparam int PMW = 5632;                      // Smallest array, pair at 002bfc
    localparam logic [PA_W-1:0] CFG1 = 24'h002bfc;  // Expected first configuration word
    typedef struct packed {
        logic [EA_W-1:0] ea;                        // Address
        logic            bm;                        // Byte mode
        logic [DW_W-1:0] exp;                       // Expected result
    } mad_row_t;
    logic                clk = 1'b0, reset = 1'b1, pm_rd, fetch_req = 1'b0, fetch_back = 1'b0;
    logic                fetch_ready, pc_load = 1'b0, fetch_valid, hw_req = 1'b0, hw_ready;
    logic                hw_valid, cfg_valid, rd_valid, win_rd;
    logic [PA_W-1:0]     pm_addr, pc_target = '0, pc, hw_addr = '0;
    logic [PW_W-1:0]     pm_rdata, fetch_word, cfg_word1, cfg_word2;
    logic [DW_W-1:0]     hw_data, rd_data, ram_rdata, win_rdata;
    logic [EA_W-1:0]     win_ea;
    mad_region_t         pc_region;
    mad_agu_req_t        rd_agu = '0, wr_agu = '0;
    mad_ram_req_t        ram_rd, ram_wr;
    int                  errors = 0, num_checks = 0;
    mad_row_t            rows [8];

    mad_decoder #(.PM_WORDS(PMW)) i_mad_decoder (.clk, .reset, .pm_rd, .pm_addr, .pm_rdata,
        .fetch_req, .fetch_back, .fetch_ready, .pc_load, .pc_target, .pc, .pc_region,
        .fetch_valid, .fetch_word, .hw_req, .hw_addr, .hw_ready, .hw_valid, .hw_data,
        .cfg_valid, .cfg_word1, .cfg_word2, .rd_agu, .wr_agu, .rd_valid, .rd_data, .ram_rd,
        .ram_rdata, .ram_wr, .win_rd, .win_ea, .win_rdata);
    mad_mem_model i_mad_mem_model (.clk, .pm_rd, .pm_addr, .pm_rdata, .ram_rd, .ram_rdata,
        .ram_wr, .win_rd, .win_ea, .win_rdata);

    always #2.5 clk = ~clk;                         // 200 MHz core clock

    // Same fill patterns as the model, worked out here independently
    function automatic logic [PW_W-1:0] pw(input logic [PA_W-1:0] a);
        return {a[7:0] ^ 8'hc3, a[15:0] ^ 16'h3c5a};
    endfunction : pw
    function automatic logic [DW_W-1:0] rw(input int i);
        return 16'(i) ^ 16'h5a3c;
    endfunction : rw
    function automatic logic [DW_W-1:0] wn(input logic [EA_W-1:0] a);
        return {a[7:0], a[15:8]} ^ 16'h0ff0;
    endfunction : wn

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Every stimulus task starts and ends at a falling edge
    task automatic dread(input mad_row_t r);
        rd_agu <= '{1'b1, r.bm, r.ea, 16'h0000};
        @(negedge clk) rd_agu.en <= 1'b0;
        @(negedge clk);
        chk({23'h0, rd_valid}, 24'h1);
        chk({8'h00, rd_data}, {8'h00, r.exp});
    endtask : dread
    task automatic dwrite(input logic [EA_W-1:0] ea, input logic bm, input logic [DW_W-1:0] d);
        wr_agu <= '{1'b1, bm, ea, d};
        @(negedge clk) wr_agu.en <= 1'b0;
        @(negedge clk);
    endtask : dwrite
    task automatic step(input logic back, input logic [PA_W-1:0] at);
        fetch_req <= 1'b1;
        fetch_back <= back;
        @(negedge clk) fetch_req <= 1'b0;
        @(negedge clk);
        chk({23'h0, fetch_valid}, 24'h1);
        chk(fetch_word, pw(at));
    endtask : step
    task automatic jump(input logic [PA_W-1:0] t);
        pc_load <= 1'b1;
        pc_target <= t;
        @(negedge clk) pc_load <= 1'b0;
        @(negedge clk);
    endtask : jump
    task automatic hread(input logic [PA_W-1:0] a, input logic [DW_W-1:0] e);
        hw_req <= 1'b1;
        hw_addr <= a;
        @(negedge clk) hw_req <= 1'b0;
        @(negedge clk);
        chk({23'h0, hw_valid}, 24'h1);
        chk({8'h00, hw_data}, {8'h00, e});
    endtask : hread
    task automatic boot();
        repeat (4) @(negedge clk);
        reset = 1'b0;
        for (int i = 0; i < 10 && cfg_valid !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
    endtask : boot
    task automatic report_and_stop();
        if (errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // Main sequence: data rows, then hand-written program and reset cases
    initial begin
        rows = '{'{16'h0010, 1'b0, rw(8)}, '{16'h0011, 1'b1, 16'(rw(8) >> 8)},
            '{16'h0010, 1'b1, rw(8) & 16'h00ff}, '{16'h1ffe, 1'b0, rw(4095)},
            '{16'h2000, 1'b0, 16'h0000}, '{16'h7fff, 1'b1, 16'h0000},
            '{16'h8000, 1'b0, wn(16'h8000)}, '{16'hfffe, 1'b0, wn(16'hfffe)}};
        boot();
        chk(cfg_word1, pw(CFG1));
        chk(cfg_word2, pw(CFG1 + 24'h2));
        chk({23'h0, hw_ready}, 24'h1);
        chk(pc, PC_RESET);
        foreach (rows[i]) dread(rows[i]);
        dwrite(16'h0021, 1'b1, 16'h00ab);
        dread('{16'h0020, 1'b0, 16'hab00 | (rw(16) & 16'h00ff)});
        dwrite(16'h0022, 1'b0, 16'h1234);
        dread('{16'h0022, 1'b0, 16'h1234});
        dwrite(16'h3000, 1'b0, 16'hffff);
        dwrite(16'h8004, 1'b0, 16'hffff);
        dread('{16'h3000, 1'b0, 16'h0000});
        dread('{16'h1000, 1'b0, rw(2048)});
        step(1'b0, 24'h0);
        step(1'b0, 24'h2);
        chk(pc, 24'h4);
        chk(24'(pc_region), 24'(MAD_REG_IVT_PRI));
        jump(24'h000101);
        chk(pc, IVT_ALT_LO);
        chk(24'(pc_region), 24'(MAD_REG_IVT_ALT));
        step(1'b1, IVT_ALT_LO);
        chk(pc, 24'h0000fe);
        jump(VEC_END);
        chk(24'(pc_region), 24'(MAD_REG_CODE));
        jump(CFG1 + 24'h2);
        chk(24'(pc_region), 24'(MAD_REG_CONFIG));
        hread(CFG1, 16'(pw(CFG1)));
        hread(CFG1 + 24'h1, 16'(pw(CFG1) >> 16));
        reset = 1'b1;
        @(negedge clk);
        chk({23'h0, cfg_valid}, 24'h0);
        chk({23'h0, hw_ready}, 24'h0);
        boot();
        chk(pc, PC_RESET);
        chk(cfg_word1, pw(CFG1));
        report_and_stop();
    end

    // Watchdog well beyond the few dozen cycles the sequence needs
    initial begin
        #20000;
        errors++;
        report_and_stop();
    end
endmodule : mad_decoder_tb
